/* lbar_requester.sv */
// Processor-side requester for the three-signal arbitration protocol
// Assumes synchronous inputs, active-high pins, external arbiter on grant
// Summary of operation
// R1 - Request asserted while an access is pending
// R2 - Request held while ownership still needed
// R3 - Request may drop regardless of grant
// R4 - Granted request rises with transfer start
// R5 - Request always actively driven, never shared
// R6 - Arbiter asserts grant to give ownership
// R7 - Grant loss releases after current cycle
// R8 - Arbiter drops grant before final termination
// R9 - Burst-inhibited line fill is one cycle
// R10 - Qualifier set: locked sequence splits at cycle
// R11 - Qualifier clear: finish whole locked sequence
// R12 - State changes on enabled rising edges
// R13 - Alternate masters assert busy while owning
// R14 - All masters share transfer-start strobe
// R15 - Start only with grant and bus free
`timescale 1ns/1ns
`default_nettype none
module lbar_requester import lbar_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_enable_in,
    // Internal access side
    input wire logic access_pending,
    input wire logic access_line,
    input wire logic access_locked,
    input wire logic lock_last,
    output logic access_started,
    output logic access_done,
    // Arbitration pins
    output logic bus_request_out,
    input wire logic bus_grant_in,
    input wire logic relinquish_qualifier_in,
    input wire logic bus_busy_in,
    output logic bus_busy_out,
    output logic bus_busy_oe_n,
    output logic tenure_end_out,
    // Transfer pins
    output logic transfer_start_strobe,
    input wire logic transfer_ack_in,
    input wire logic transfer_error_in,
    input wire logic transfer_retry_in,
    // Status
    output logic bus_owned
);
    typedef struct packed {
        lbar_state_t state;
        logic in_lock;
        logic cyc_lock_last;
        logic keep;
    } lbar_st_t;
    lbar_st_t st_r;
    lbar_st_t st_nxt;

    logic term;
    logic last_beat;
    logic start;
    logic cycle_end;
    logic bus_free;

    assign term = transfer_ack_in || transfer_error_in || transfer_retry_in;
    assign bus_free = !bus_busy_in || st_r.state != LBAR_IDLE;
    // New cycle only with grant and free bus, or within kept lock [R15] [R11]
    assign start = access_pending && (st_r.state == LBAR_IDLE || st_r.state == LBAR_OWN)
        && ((bus_grant_in && bus_free) || st_r.keep);
    // Error or retry ends at once, ack only on the last beat [R9]
    assign cycle_end = st_r.state == LBAR_CYCLE
        && ((transfer_ack_in && last_beat) || transfer_error_in || transfer_retry_in);

    lbar_beat_cnt u_beats (
        .clk(clk),
        .nrst(nrst),
        .clock_enable_in(clock_enable_in),
        .start(start),
        .line_mode(access_line),
        .beat_done(st_r.state == LBAR_CYCLE && transfer_ack_in),
        .last_beat(last_beat)
    );

    // Request follows pending access, drops freely, rises with start [R1] [R2] [R3] [R4]
    assign bus_request_out = access_pending || st_r.state == LBAR_CYCLE;
    // Push-pull request, never tristated [R5]
    assign transfer_start_strobe = start && clock_enable_in; // [R4] [R14]
    assign access_started = transfer_start_strobe;
    assign access_done = cycle_end && clock_enable_in;
    assign bus_owned = st_r.state != LBAR_IDLE;
    // Busy driven low-active-enable while owned [R13]
    assign bus_busy_out = bus_owned;
    assign bus_busy_oe_n = !bus_owned;
    // Tenure-end is unused in this protocol; held negated
    assign tenure_end_out = 1'b0;

    always_comb begin
        st_nxt = st_r;
        case (st_r.state)
            LBAR_IDLE, LBAR_OWN: begin
                if (start) begin
                    st_nxt.state = LBAR_CYCLE;
                    st_nxt.cyc_lock_last = access_locked && lock_last;
                    if (access_locked && !st_r.in_lock) begin
                        st_nxt.in_lock = 1'b1;
                    end
                end else if (st_r.state == LBAR_OWN && !bus_grant_in) begin
                    if (st_r.in_lock && !relinquish_qualifier_in) begin
                        st_nxt.keep = 1'b1; // [R11]
                    end else if (!st_r.keep) begin
                        st_nxt.state = LBAR_IDLE; // [R6] [R10]
                    end
                end
            end
            LBAR_CYCLE: begin
                // Hold grant loss until cycle ends [R7] [R8]
                if (!bus_grant_in && st_r.in_lock && !relinquish_qualifier_in) begin
                    st_nxt.keep = 1'b1; // [R11]
                end
                if (cycle_end) begin
                    if (st_r.cyc_lock_last) begin
                        st_nxt.in_lock = 1'b0;
                        st_nxt.keep = 1'b0;
                    end
                    if (st_nxt.keep && !st_r.cyc_lock_last) begin
                        st_nxt.state = LBAR_HOLD;
                    end else if (bus_grant_in) begin
                        st_nxt.state = LBAR_OWN;
                    end else begin
                        st_nxt.state = LBAR_IDLE; // [R7] [R10]
                    end
                end
            end
            LBAR_HOLD: begin
                st_nxt.state = LBAR_OWN; // [R11]
            end
            default: begin
                st_nxt.state = LBAR_IDLE;
            end
        endcase
    end

    // Enabled rising edges only, but reset loads on any rising edge [R12]
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r.state <= LBAR_IDLE;
            st_r.in_lock <= LBAR_FLAG_RST;
            st_r.cyc_lock_last <= LBAR_FLAG_RST;
            st_r.keep <= LBAR_FLAG_RST;
        end else if (clock_enable_in) begin
            st_r <= st_nxt;
        end
    end

    // Checks
    start_needs_grant_a: assert property (@(posedge clk) disable iff (!nrst) // [R15]
        transfer_start_strobe && !st_r.keep |-> bus_grant_in)
        else $error("start without grant");
    start_bus_free_a: assert property (@(posedge clk) disable iff (!nrst) // [R15]
        transfer_start_strobe && st_r.state == LBAR_IDLE |-> !bus_busy_in)
        else $error("start while bus busy");
    start_with_req_a: assert property (@(posedge clk) disable iff (!nrst) // [R4]
        transfer_start_strobe |-> bus_request_out)
        else $error("start without request");
    strobe_single_a: assert property (@(posedge clk) disable iff (!nrst) // [R4]
        transfer_start_strobe |=> !transfer_start_strobe)
        else $error("strobe longer than one cycle");
    req_when_pending_a: assert property (@(posedge clk) disable iff (!nrst) // [R1]
        access_pending |-> bus_request_out)
        else $error("pending access without request");
    req_in_cycle_a: assert property (@(posedge clk) disable iff (!nrst) // [R2]
        st_r.state == LBAR_CYCLE |-> bus_request_out)
        else $error("request dropped mid cycle");
    req_idle_drop_a: assert property (@(posedge clk) disable iff (!nrst) // [R3]
        !access_pending && st_r.state != LBAR_CYCLE |-> !bus_request_out)
        else $error("request held without need");
    keep_cycle_a: assert property (@(posedge clk) disable iff (!nrst) // [R7]
        clock_enable_in && st_r.state == LBAR_CYCLE && !term |=> st_r.state == LBAR_CYCLE)
        else $error("cycle left without termination");
    release_after_a: assert property (@(posedge clk) disable iff (!nrst) // [R7]
        clock_enable_in && access_done && !bus_grant_in && !st_r.in_lock |=> !bus_owned)
        else $error("bus kept after cycle");
    own_release_a: assert property (@(posedge clk) disable iff (!nrst) // [R7]
        clock_enable_in && st_r.state == LBAR_OWN && !bus_grant_in && !st_r.keep
        && !st_r.in_lock |=> !bus_owned)
        else $error("idle bus kept without grant");
    line_four_beats_a: assert property (@(posedge clk) disable iff (!nrst) // [R9]
        clock_enable_in && start && access_line |=>
        !(clock_enable_in && term && last_beat))
        else $error("line cycle ended early");
    line_beat_stay_a: assert property (@(posedge clk) disable iff (!nrst) // [R9]
        clock_enable_in && st_r.state == LBAR_CYCLE && transfer_ack_in && !last_beat
        && !transfer_error_in && !transfer_retry_in |=> st_r.state == LBAR_CYCLE)
        else $error("line cycle left mid line");
    split_lock_a: assert property (@(posedge clk) disable iff (!nrst) // [R10]
        clock_enable_in && cycle_end && !bus_grant_in && !st_r.keep
        && !st_nxt.keep |=> st_r.state == LBAR_IDLE)
        else $error("bus not released");
    keep_lock_a: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        clock_enable_in && cycle_end && st_r.keep && !st_r.cyc_lock_last |=> bus_owned)
        else $error("locked sequence split");
    lock_grant_keep_a: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        clock_enable_in && st_r.state == LBAR_CYCLE && st_r.in_lock && !st_r.cyc_lock_last
        && !bus_grant_in && !relinquish_qualifier_in |=> st_r.keep)
        else $error("grant loss not ignored in lock");
    hold_to_own_a: assert property (@(posedge clk) disable iff (!nrst) // [R11]
        clock_enable_in && st_r.state == LBAR_HOLD |=> st_r.state == LBAR_OWN)
        else $error("hold did not return to owned");
    frozen_state_a: assert property (@(posedge clk) disable iff (!nrst) // [R12]
        !clock_enable_in |=> $stable(st_r))
        else $error("state moved while disabled");
    busy_drive_a: assert property (@(posedge clk) disable iff (!nrst) // [R13]
        bus_owned |-> !bus_busy_oe_n && bus_busy_out)
        else $error("busy not driven");
    single_cov_c: cover property (@(posedge clk) disable iff (!nrst)
        transfer_start_strobe ##[1:20] access_done);
    line_cov_c: cover property (@(posedge clk) disable iff (!nrst)
        transfer_start_strobe && access_line);
    hold_cov_c: cover property (@(posedge clk) disable iff (!nrst)
        st_r.state == LBAR_HOLD);
    keep_cov_c: cover property (@(posedge clk) disable iff (!nrst)
        st_r.keep && transfer_start_strobe);
    split_cov_c: cover property (@(posedge clk) disable iff (!nrst)
        access_done && st_r.in_lock && !bus_grant_in && relinquish_qualifier_in);
endmodule
`default_nettype wire

/* lbar_pkg.sv */
// Package for the legacy bus arbitration requester
// Assumes one bus clock domain and active-low bus pins modelled active high
`default_nettype none
package lbar_pkg;
    // Beats in a burst-inhibited line transfer
    localparam logic [2:0] LBAR_LINE_BEATS = 3'h4;
    localparam logic [2:0] LBAR_BEAT_RST = 3'h0;
    localparam logic LBAR_FLAG_RST = 1'h0;
    typedef enum logic [1:0] {LBAR_IDLE, LBAR_OWN, LBAR_CYCLE, LBAR_HOLD} lbar_state_t;
endpackage
`default_nettype wire

/* lbar_beat_cnt.sv */
// Beat counter for one bus cycle
// Assumes terminations arrive synchronous to clk
`timescale 1ns/1ns
`default_nettype none
module lbar_beat_cnt import lbar_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_enable_in,
    // Control
    input wire logic start,
    input wire logic line_mode,
    input wire logic beat_done,
    // Status
    output logic last_beat
);
    typedef struct packed {
        logic [2:0] left;
    } lbar_cnt_t;
    lbar_cnt_t st_r;
    lbar_cnt_t st_nxt;

    // Line transfer is one cycle of four beats [R9]
    assign last_beat = (st_r.left == 3'h1) || (st_r.left == 3'h0);

    always_comb begin
        st_nxt = st_r;
        if (start) begin
            st_nxt.left = line_mode ? LBAR_LINE_BEATS : 3'h1;
        end else if (beat_done && st_r.left != 3'h0) begin
            st_nxt.left = st_r.left - 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_r.left <= LBAR_BEAT_RST;
        end else if (clock_enable_in) begin
            st_r <= st_nxt;
        end
    end
endmodule
`default_nettype wire

/* lbar_arb_model.sv */
// Far-side model: bus arbiter plus one alternate master
// Assumes the bench commands grant and alternate tenure
`timescale 1ns/1ns
`default_nettype none
module lbar_arb_model (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    input wire logic clock_enable_in,
    // Bench commands
    input wire logic grant_wanted,
    input wire logic other_owns,
    // Arbitration pins
    output logic bus_grant_in,
    output logic bus_busy_in
);
    wire logic upd = ~nrst | clock_enable_in;
    always_ff @(posedge clk) if (upd) bus_grant_in <= nrst & grant_wanted;
    always_ff @(posedge clk) if (upd) bus_busy_in <= nrst & other_owns;
endmodule
`default_nettype wire

/* lbar_requester_tb.sv */
// Bench for the legacy bus arbitration requester
// Assumes the arbiter model on the far side and a 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
module lbar_requester_tb import lbar_pkg::*;;
    logic clk = 1'b0, nrst = 1'b0, ce = 1'b1, pend = 1'b0, want = 1'b0;
    logic other = 1'b0, qual = 1'b0, ack = 1'b0;
    logic [2:0] kind = 3'h0;
    logic started, done, req, alt, bbo, bbo_n, ts, owned, grant, tend;
    wire logic busy;
    int fail_count = 0, check_count = 0, n;
    assign busy = alt | (~bbo_n & bbo);
    lbar_requester uut (.clk(clk), .nrst(nrst), .clock_enable_in(ce), .access_pending(pend),
        .access_line(kind[2]), .access_locked(kind[1]), .lock_last(kind[0]),
        .access_started(started), .access_done(done), .bus_request_out(req),
        .bus_grant_in(grant), .relinquish_qualifier_in(qual), .bus_busy_in(busy),
        .bus_busy_out(bbo), .bus_busy_oe_n(bbo_n), .tenure_end_out(tend),
        .transfer_start_strobe(ts), .transfer_ack_in(ack), .transfer_error_in(1'b0),
        .transfer_retry_in(1'b0), .bus_owned(owned));
    lbar_arb_model arb (.clk(clk), .nrst(nrst), .clock_enable_in(ce), .grant_wanted(want),
        .other_owns(other), .bus_grant_in(grant), .bus_busy_in(alt));
    initial forever #5 clk = ~clk;
    task automatic chk(input logic [1:0] got, input logic [1:0] exp, input string msg);
        check_count++;
        if (got !== exp) $display("mismatch %0t %s", $time, msg);
        if (got !== exp) fail_count++;
    endtask
    task automatic complete_run();
        if (fail_count == 0 && check_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic grant_on(input logic q);
        @(posedge clk) want <= 1'b1;
        qual <= q;
        repeat (2) @(posedge clk);
    endtask
    task automatic start_acc(input logic [2:0] k);
        @(posedge clk) pend <= 1'b1;
        kind <= k;
        #2;
        for (n = 0; ts !== 1'b1 && n < 8; n++) @(posedge clk) #2;
        chk({started, req}, 2'h3, "start");
        @(posedge clk) pend <= 1'b0;
        #2 chk({owned, bbo}, 2'h3, "own");
    endtask
    task automatic term(input int b, input logic eo);
        for (int i = 0; i < b; i++) begin
            @(posedge clk) ack <= 1'b1;
            #2 chk({done, owned}, {i == b - 1, 1'b1}, "beat");
        end
        @(posedge clk) ack <= 1'b0;
        #2 chk(owned, eo, "release");
    endtask
    task automatic s_xfer(input logic l);
        grant_on(1'b0);
        start_acc({l, 2'h0});
        chk(n == 0, 1'b1, "late");
        @(posedge clk) want <= 1'b0;
        repeat (2) @(posedge clk);
        #2 chk({bbo_n, req}, 2'h1, "hold");
        chk({tend, bbo}, 2'h1, "busy");
        term(l ? int'(LBAR_LINE_BEATS) : 1, 1'b0);
    endtask
    task automatic s_lock(input logic q);
        grant_on(q);
        start_acc(3'h2);
        @(posedge clk) want <= 1'b0;
        term(1, ~q);
        if (q) grant_on(q);
        start_acc(3'h3);
        if (q) @(posedge clk) want <= 1'b0;
        term(1, 1'b0);
    endtask
    task automatic s_wait(input logic c);
        grant_on(1'b0);
        other <= ~c;
        ce <= ~c;
        other <= #40 1'b0;
        ce <= #40 1'b1;
        start_acc(3'h0);
        chk(n >= 3 && n < 8, 1'b1, "wait");
        @(posedge clk) want <= 1'b0;
        term(1, 1'b0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #2 chk({bbo_n, req}, 2'h2, "reset");
        @(posedge clk) nrst <= 1'b1;
        for (int i = 0; i < 2; i++) s_xfer(i[0]);
        for (int i = 0; i < 2; i++) s_lock(i[0]);
        for (int i = 0; i < 2; i++) s_wait(i[0]);
        complete_run();
    end
    initial begin
        #3000;
        fail_count++;
        complete_run();
    end
endmodule
`default_nettype wire
